// >>> design/rcw_map.vh
`ifndef RCW_MAP_VH
`define RCW_MAP_VH
// register indices; the apb byte address is four times the index
`define RCW_IDX_STATUS 12'hFCC
`define RCW_IDX_UNLOCK 12'hFDF
`define RCW_IDX_CTRL 12'hFE0
`define RCW_RST_STATUS 8'h00
`define RCW_BIT_ARM 7
`define RCW_BIT_FLASH 6
`define RCW_BIT_CALABN 5
`define RCW_BIT_CALRST 4
`define RCW_BIT_VD2 3
`define RCW_BIT_VD1 2
`define RCW_BIT_DEADLOCK 1
`define RCW_BIT_WDT 0
`define RCW_CODE_CLEAR 8'h71
`define RCW_VEC_LO 16'hFFFE
`define RCW_VEC_HI 16'hFFFF
`define RCW_WARMUP_CYCLES 16
`endif

// >>> design/rcw_reset_seq.v
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rcw_map.vh"
module rcw_reset_seq #(
	parameter WARMUP_CYCLES = `RCW_WARMUP_CYCLES,
	parameter CAL_WORDS = 4
) (
	// apb clock and reset (power-on)
	input wire pclk,
	input wire presetn,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [15:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// reset sources, asynchronous to pclk
	input wire ext_reset_n,
	input wire flash_standby_rst,
	input wire calibration_rst,
	input wire voltage_detector2_rst,
	input wire voltage_detector1_rst,
	input wire clock_deadlock_rst,
	input wire watchdog_rst,
	// calibration store interface
	output reg cal_rd,
	output reg [7:0] cal_addr,
	input wire [7:0] cal_data,
	input wire cal_bad,
	output reg [7:0] cal_word,
	// system state outputs
	output reg core_reset,
	output reg warmup_busy,
	output reg [15:0] fetch_addr,
	output reg fetch_start,
	output reg interrupt_master_enable,
	output reg individual_interrupt_enables,
	output reg interrupt_latches,
	output reg high_osc_en,
	output reg low_osc_en,
	output reg [7:0] prescaler,
	output reg register_bank_selector
);
	localparam S_RESET = 3'b001;
	localparam S_WARM = 3'b010;
	localparam S_RUN = 3'b100;

	// two-flop synchronisers for all asynchronous sources
	reg [6:0] src_s1_q;
	reg [6:0] src_s2_q;
	wire [6:0] src_raw = {~ext_reset_n, flash_standby_rst, calibration_rst,
		voltage_detector2_rst, voltage_detector1_rst, clock_deadlock_rst, watchdog_rst};
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_s1_q <= 7'h00;
			src_s2_q <= 7'h00;
		end else begin
			src_s1_q <= src_raw;
			src_s2_q <= src_s1_q;
		end
	end
	wire ext_rst = src_s2_q[6];
	wire [5:0] int_rst = src_s2_q[5:0];
	wire any_rst = ext_rst | (|int_rst);

	// apb decode; always ready, no wait states
	wire wr = psel & penable & pwrite;
	wire rd_sel = psel & ~pwrite;
	assign pready = 1'b1;
	// one aligned word per register, so the byte address is index times four
	wire hit_status = (paddr == {2'b00, `RCW_IDX_STATUS, 2'b00});
	wire hit_unlock = (paddr == {2'b00, `RCW_IDX_UNLOCK, 2'b00});
	wire hit_ctrl = (paddr == {2'b00, `RCW_IDX_CTRL, 2'b00});
	wire mapped = hit_status || hit_unlock || hit_ctrl;
	assign pslverr = psel & penable & ~mapped;

	// arm bit and flags
	reg arm_q;
	reg [6:0] flags_q;
	reg cal_abn_set;
	wire clear_go = wr && hit_unlock &&
		(pwdata[7:0] == `RCW_CODE_CLEAR) && arm_q;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arm_q <= 1'b0;
		end else if (any_rst || clear_go) begin
			arm_q <= 1'b0; // self-clears after the clear
		end else if (wr && hit_status) begin
			arm_q <= pwdata[`RCW_BIT_ARM];
		end
	end
	// flags: power-on, external and armed software clear; internal resets only set
	wire [6:0] set_v = {int_rst[5], cal_abn_set, int_rst[4:0]};
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_q <= 7'h00;
		end else if (ext_rst) begin
			flags_q <= 7'h00;
		end else if (clear_go) begin
			flags_q <= set_v; // set wins over software clear
		end else begin
			flags_q <= flags_q | set_v;
		end
	end

	// read data from flops; arm bit reads zero
	reg [31:0] rdata_q;
	assign prdata = rdata_q;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= 32'h0000_0000;
		end else if (rd_sel && !penable) begin
			if (hit_status)
				rdata_q <= {24'h000000, 1'b0, flags_q};
			else if (hit_ctrl)
				rdata_q <= {29'h0, fetch_start, warmup_busy, core_reset};
			else
				rdata_q <= 32'h0000_0000; // unlock register write-only
		end
	end

	// sequencer
	reg [2:0] st_q;
	reg [15:0] cnt_q;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= S_RESET;
			cnt_q <= 16'h0000;
			cal_rd <= 1'b0;
			cal_addr <= 8'h00;
			cal_word <= 8'h00;
			cal_abn_set <= 1'b0;
			fetch_addr <= `RCW_VEC_LO;
			fetch_start <= 1'b0;
		end else if (any_rst) begin
			st_q <= S_RESET;
			cnt_q <= 16'h0000;
			cal_rd <= 1'b0;
			cal_addr <= 8'h00;
			cal_abn_set <= 1'b0;
			fetch_start <= 1'b0;
		end else begin
			cal_abn_set <= 1'b0;
			fetch_start <= 1'b0;
			case (st_q)
			S_RESET: begin
				st_q <= S_WARM;
				cnt_q <= 16'h0000;
			end
			S_WARM: begin
				cnt_q <= cnt_q + 16'h0001;
				// load calibration words early in warm-up
				cal_rd <= (cnt_q < CAL_WORDS);
				if (cal_rd) begin
					cal_word <= cal_data;
					cal_addr <= cal_addr + 8'h01;
					if (cal_bad)
						cal_abn_set <= 1'b1;
				end
				if (cnt_q == WARMUP_CYCLES - 1) begin
					st_q <= S_RUN;
					cal_rd <= 1'b0;
					fetch_addr <= `RCW_VEC_LO;
					fetch_start <= 1'b1;
				end
			end
			S_RUN: begin
				st_q <= S_RUN;
			end
			default: st_q <= S_RESET;
			endcase
		end
	end

	// held system states, all reset and warm-up values
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_reset <= 1'b1;
			warmup_busy <= 1'b0;
			interrupt_master_enable <= 1'b0;
			individual_interrupt_enables <= 1'b0;
			interrupt_latches <= 1'b0;
			high_osc_en <= 1'b1;
			low_osc_en <= 1'b0;
			prescaler <= 8'h00;
			register_bank_selector <= 1'b0;
		end else begin
			core_reset <= any_rst | (st_q != S_RUN);
			warmup_busy <= ~any_rst & (st_q == S_WARM);
			interrupt_master_enable <= 1'b0;
			individual_interrupt_enables <= 1'b0;
			interrupt_latches <= 1'b0;
			high_osc_en <= 1'b1;
			low_osc_en <= 1'b0;
			prescaler <= 8'h00; // held at zero in every state, also after release
			register_bank_selector <= 1'b0;
		end
	end
	// is software's duty; the clear acts on the unlock write edge
	wire unused_ok = &{1'b0, pwdata[31:8], fetch_addr[0]};
endmodule
`default_nettype wire

// >>> dv/rcw_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module rcw_monitor #(
	parameter WARMUP_CYCLES = 16,
	parameter CAL_WORDS = 4
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// watched ports
	input wire logic [31:0] prdata,
	input wire logic watchdog_rst,
	input wire logic core_reset,
	input wire logic fetch_start,
	input wire logic [15:0] fetch_addr,
	input wire logic interrupt_master_enable,
	input wire logic individual_interrupt_enables,
	input wire logic interrupt_latches,
	input wire logic high_osc_en,
	input wire logic low_osc_en,
	input wire logic [7:0] prescaler,
	input wire logic register_bank_selector
);
	// one domain, so one clock and one disable for all
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_arm_reads_zero: assert property (prdata[7] == 1'b0)
		else $error("arm bit read as one");
	a_src_holds: assert property ($rose(watchdog_rst) |-> ##[1:4] core_reset)
		else $error("source did not hold reset");
	a_ints_quiet: assert property (core_reset |-> !(interrupt_master_enable
		|| individual_interrupt_enables || interrupt_latches))
		else $error("interrupt state not zero");
	a_osc_state: assert property (core_reset |-> high_osc_en && !low_osc_en)
		else $error("oscillator state wrong");
	a_presc_zero: assert property (core_reset |-> prescaler == 8'h00)
		else $error("prescaler not zero");
	a_bank_zero: assert property (core_reset |-> !register_bank_selector)
		else $error("bank selector not zero");
	a_vector_addr: assert property (fetch_start |-> fetch_addr == 16'hFFFE)
		else $error("wrong vector address");
	a_start_release: assert property (fetch_start |=> !fetch_start && !core_reset)
		else $error("core not released after start");
endmodule
bind rcw_reset_seq rcw_monitor #(.WARMUP_CYCLES(WARMUP_CYCLES), .CAL_WORDS(CAL_WORDS)) i_mon (
	.pclk, .presetn, .prdata, .watchdog_rst, .core_reset, .fetch_start, .fetch_addr,
	.interrupt_master_enable, .individual_interrupt_enables, .interrupt_latches,
	.high_osc_en, .low_osc_en, .prescaler, .register_bank_selector);
`default_nettype wire

// >>> dv/test_reset_cause_and_warmup_release.sv
`timescale 1ns/1ps
`default_nettype none
module test_reset_cause_and_warmup_release;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic ext_reset_n = 1, cal_bad = 0, err;
	logic [15:0] paddr = 16'h0000;
	wire [7:0] cal_word;
	logic [31:0] pwdata = 32'h0, rd;
	logic [5:0] src = 6'h00;
	wire [31:0] prdata;
	wire pready, pslverr, core_reset;
	int n_errors = 0, num_checks = 0;
	// source pulse beside the sticky status it should leave
	logic [13:0] rows [6] = '{14'h0101, 14'h0203, 14'h0407, 14'h080F, 14'h101F, 14'h205F};
	rcw_reset_seq #(.WARMUP_CYCLES(16), .CAL_WORDS(4)) i_rcw_reset_seq (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_reset_n(ext_reset_n), .flash_standby_rst(src[5]), .calibration_rst(src[4]),
		.voltage_detector2_rst(src[3]), .voltage_detector1_rst(src[2]),
		.clock_deadlock_rst(src[1]), .watchdog_rst(src[0]), .cal_rd(), .cal_addr(),
		.cal_data(8'h5A), .cal_bad(cal_bad), .cal_word(cal_word), .core_reset(core_reset),
		.warmup_busy(), .fetch_addr(), .fetch_start(), .interrupt_master_enable(),
		.individual_interrupt_enables(), .interrupt_latches(), .high_osc_en(),
		.low_osc_en(), .prescaler(), .register_bank_selector());
	initial begin
		forever #5 pclk = ~pclk;
	end
	task chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// apb master: setup, access, hold until pready sampled high
	task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// pulse sources past the synchroniser, then wait out warm-up
	task fire(input logic [5:0] s);
		src <= s;
		repeat (4) @(posedge pclk);
		src <= 6'h00;
		repeat (3) @(posedge pclk);
		for (int k = 0; k < 300 && core_reset !== 1'b0; k++) @(posedge pclk);
	endtask
	task tally_and_finish;
		if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		#200000;
		n_errors++;
		tally_and_finish;
	end
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			fire(rows[i][13:8]);
			apb(0, 16'h3F30, 0);
			chk(rd, {24'h0, rows[i][7:0]});
		end
		// second watchdog pulse in mid warm-up must restart the count
		cal_bad <= 1'b1;
		src <= 6'h01;
		repeat (4) @(posedge pclk);
		src <= 6'h00;
		repeat (8) @(posedge pclk);
		src <= 6'h01;
		repeat (4) @(posedge pclk);
		src <= 6'h00;
		repeat (10) @(posedge pclk);
		chk(core_reset, 1);
		fire(0);
		cal_bad <= 1'b0;
		chk(cal_word, 8'h5A);
		apb(0, 16'h3F80, 0);
		chk(rd, 32'h00);
		apb(0, 16'h3F30, 0);
		chk(rd, 32'h7F);
		apb(1, 16'h3F7C, 32'h71);
		apb(0, 16'h3F30, 0);
		chk(rd, 32'h7F);
		apb(1, 16'h3F30, 32'h80);
		apb(0, 16'h3F30, 0);
		chk(rd, 32'h7F);
		apb(1, 16'h3F7C, 32'h72);
		apb(0, 16'h3F30, 0);
		chk(rd, 32'h7F);
		apb(1, 16'h3F7C, 32'h71);
		apb(0, 16'h3F30, 0);
		chk(rd, 32'h00);
		apb(0, 16'h0400, 0);
		chk(err, 1);
		// external reset clears flags left by an internal one
		fire(6'h02);
		ext_reset_n <= 1'b0;
		repeat (4) @(posedge pclk);
		ext_reset_n <= 1'b1;
		fire(0);
		apb(0, 16'h3F30, 0);
		chk(rd, 32'h00);
		fire(6'h01);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(core_reset, 1);
		presetn <= 1'b1;
		fire(0);
		apb(0, 16'h3F30, 0);
		chk(rd, 32'h00);
		tally_and_finish;
	end
endmodule
`default_nettype wire
